// ===== hdl/twcp_port.v
// three-wire serial configuration port with its register file
`timescale 1ns/1ps
`include "twcp_regs.vh"

// =====================================================================
// Notes on behaviour
// R1 - single or multibyte transfers, either bit order
// R2 - one shared pin or two one-way pins
// R3 - pin mode, bit order in serial_port_config[7:6]
// R4 - config change acts after byte's last bit
// R5 - host sends later bytes in new format
// R6 - host should change config in single byte
// R7 - all bits timed by serial clock edges
// R8 - transfer can be aborted, port returns idle
// R9 - every config register writable and readable
// R10 - read-only revision register at 0x1F
// R11 - instruction: rw, byte count, start address
// R12 - chip select high then low restarts instruction
// R13 - sample on rising, drive falling, high-z idle
// R14 - address steps down msb-first, up lsb-first
// R15 - incomplete byte on abort writes nothing

module twcp_port #(
    parameter [7:0] REVISION_CODE = 8'h5a  // arbitrary value
) (
    input  wire         clk_sys,
    input  wire         reset_n,
    input  wire         clk_en,
    input  wire         sclk,
    input  wire         chip_select_n,
    input  wire         sdio_in,
    output wire         sdio_out,
    output wire         sdio_oe,
    output wire         serial_data_out,
    output wire         serial_data_out_oe,
    output wire [255:0] config_regs
);

    // =================================================================
    // pin synchronisers and serial clock edge detection
    reg [2:0] sclk_sync_reg;
    reg [1:0] cs_sync_reg;
    reg [1:0] din_sync_reg;

    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sclk_sync_reg <= 3'h0;
            cs_sync_reg   <= 2'h3;
            din_sync_reg  <= 2'h0;
        end else if (clk_en) begin
            sclk_sync_reg <= {sclk_sync_reg[1:0], sclk};
            cs_sync_reg   <= {cs_sync_reg[0], chip_select_n};
            din_sync_reg  <= {din_sync_reg[0], sdio_in};
        end
    end

    // the link clock must stay well below clk_sys/4: each level has to
    // be seen by two flops before its edge is reported
    // bit 0 of each synchroniser feeds only bit 1
    wire sclk_rise = sclk_sync_reg[1] & ~sclk_sync_reg[2];  // [R7]
    wire sclk_fall = ~sclk_sync_reg[1] & sclk_sync_reg[2];  // [R7]
    wire cs_active = ~cs_sync_reg[1];
    wire din       = din_sync_reg[1];

    // =================================================================
    // register file
    reg  [7:0] regs_reg [0:31];
    wire       wr_commit;
    wire [4:0] wr_addr;
    wire [7:0] wr_data;
    // widened so the slot compare meets the loop index at its own width
    wire [31:0] wr_index = {27'h0, wr_addr};

    // slot 31 keeps no storage: the revision code is a constant and a
    // write aimed at it is dropped
    genvar gi;
    generate
        for (gi = 0; gi < 32; gi = gi + 1) begin : g_reg
            always @(posedge clk_sys or negedge reset_n) begin
                if (!reset_n) begin
                    regs_reg[gi] <= `TWCP_RST_REG;
                end else if (clk_en && wr_commit &&
                             wr_index == gi &&
                             wr_addr != `TWCP_ADDR_REVISION) begin
                    regs_reg[gi] <= wr_data;  // [R9]
                end
            end
            assign config_regs[gi*8 +: 8] = regs_reg[gi];
        end
    endgenerate

    // config bits read straight from the register so a write lands
    // the moment its last bit is taken, mid-transfer included
    wire bidir     = regs_reg[`TWCP_ADDR_PORT_CFG][`TWCP_CFG_BIDIR_BIT];
    wire lsb_first = regs_reg[`TWCP_ADDR_PORT_CFG][`TWCP_CFG_LSB_BIT];
    // [R3] [R4] [R5]
    // cost: the rest of the frame must follow the new format at once

    // read data is fetched one byte ahead, at the byte boundary, so the
    // first bit can go out on the very next falling edge
    function [7:0] read_reg;
        input [4:0] addr;
        begin
            if (addr == `TWCP_ADDR_REVISION) begin
                read_reg = REVISION_CODE;  // [R10]
            end else begin
                read_reg = regs_reg[addr];  // [R9]
            end
        end
    endfunction

    // =================================================================
    // transfer state machine
    // one-hot states; the default arm pulls an illegal code back to idle
    localparam [2:0] ST_INSTR = 3'b001;
    localparam [2:0] ST_DATA  = 3'b010;
    localparam [2:0] ST_DONE  = 3'b100;

    reg  [2:0] state_reg;
    reg  [2:0] bit_cnt_reg;
    reg  [7:0] shift_reg;
    reg        is_read_reg;
    reg  [1:0] bytes_left_reg;
    reg  [4:0] addr_reg;
    reg  [7:0] tx_byte_reg;
    reg        out_bit_reg;

    // byte as it will stand once the current input bit is shifted in
    wire [7:0] shift_next = lsb_first ? {din, shift_reg[7:1]}
                                      : {shift_reg[6:0], din};  // [R1]
    wire       byte_end   = sclk_rise && bit_cnt_reg == `TWCP_LAST_BIT;

    // next address stops at the end of the map rather than wrapping
    wire [4:0] addr_step =
        lsb_first ? ((addr_reg == `TWCP_ADDR_HIGHEST) ? addr_reg
                                                      : addr_reg + 5'h1)
                  : ((addr_reg == `TWCP_ADDR_LOWEST)  ? addr_reg
                                                      : addr_reg - 5'h1);
    // [R14]

    assign wr_commit = cs_active && state_reg == ST_DATA && byte_end &&
                       !is_read_reg;  // [R15]
    assign wr_addr   = addr_reg;
    assign wr_data   = shift_next;

    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_reg      <= ST_INSTR;
            bit_cnt_reg    <= 3'h0;
            shift_reg      <= 8'h00;
            is_read_reg    <= 1'b0;
            bytes_left_reg <= 2'h0;
            addr_reg       <= 5'h00;
            tx_byte_reg    <= 8'h00;
            out_bit_reg    <= 1'b0;
        end else if (clk_en) begin
            if (!cs_active) begin
                // chip select high aborts and rearms for an instruction
                state_reg   <= ST_INSTR;  // [R8] [R12]
                bit_cnt_reg <= 3'h0;  // [R15]
                is_read_reg <= 1'b0;
            end else begin
                // clocks past the last counted byte shift nothing, so a
                // host that clocks on cannot disturb the register file
                if (sclk_rise && state_reg != ST_DONE) begin
                    shift_reg   <= shift_next;  // [R13]
                    bit_cnt_reg <= bit_cnt_reg + 3'h1;
                end
                case (state_reg)
                    ST_INSTR: begin
                        if (byte_end) begin
                            // [R11]
                            // the count field holds bytes minus one
                            is_read_reg <= shift_next[`TWCP_INS_RW_BIT];
                            bytes_left_reg <=
                                shift_next[`TWCP_INS_CNT_HI:
                                           `TWCP_INS_CNT_LO];
                            addr_reg <=
                                shift_next[`TWCP_INS_ADDR_HI:0];
                            tx_byte_reg <=
                                read_reg(shift_next[`TWCP_INS_ADDR_HI:0]);
                            state_reg <= ST_DATA;
                        end
                    end
                    ST_DATA: begin
                        if (sclk_fall && is_read_reg) begin
                            // [R13]
                            out_bit_reg <= lsb_first
                                ? tx_byte_reg[bit_cnt_reg]
                                : tx_byte_reg[`TWCP_LAST_BIT - bit_cnt_reg];
                        end
                        if (byte_end) begin
                            addr_reg    <= addr_step;  // [R14]
                            tx_byte_reg <= read_reg(addr_step);
                            if (bytes_left_reg == 2'h0) begin
                                state_reg <= ST_DONE;  // [R1]
                            end else begin
                                bytes_left_reg <= bytes_left_reg - 2'h1;
                            end
                        end
                    end
                    ST_DONE: begin
                        // extra clocks ignored until chip select rises
                        state_reg <= ST_DONE;
                    end
                    default: begin
                        state_reg <= ST_INSTR;
                    end
                endcase
            end
        end
    end

    // =================================================================
    // data pins, released whenever chip select is high
    // both pins share one output flop; only the enables tell them apart.
    // out_bit_reg moves two to three clk_sys after a pin fall, well
    // before the host samples on the next rise
    assign sdio_out           = out_bit_reg;
    assign serial_data_out    = out_bit_reg;
    assign sdio_oe            = cs_active && bidir && is_read_reg &&
                                state_reg == ST_DATA;  // [R2] [R13]
    assign serial_data_out_oe = cs_active && !bidir;  // [R2] [R13]

endmodule // twcp_port

// ===== pkg/twcp_regs.vh
// constants for the three-wire configuration port
`ifndef TWCP_REGS_VH
`define TWCP_REGS_VH

// register addresses
`define TWCP_ADDR_PORT_CFG   5'h00
`define TWCP_ADDR_REVISION   5'h1f
`define TWCP_ADDR_LOWEST     5'h00
`define TWCP_ADDR_HIGHEST    5'h1f

// fields of serial_port_config
`define TWCP_CFG_BIDIR_BIT   7
`define TWCP_CFG_LSB_BIT     6

// reset values
`define TWCP_RST_REG         8'h00

// instruction byte fields
`define TWCP_INS_RW_BIT      7
`define TWCP_INS_CNT_HI      6
`define TWCP_INS_CNT_LO      5
`define TWCP_INS_ADDR_HI     4

// bits per byte, last bit index
`define TWCP_LAST_BIT        3'h7

`endif

// ===== verif/twcp_checker.sv
// port-level checker for the configuration port
`timescale 1ns/1ps
module twcp_checker (
    input wire         clk_sys,
    input wire         reset_n,
    input wire         sclk,
    input wire         chip_select_n,
    input wire         sdio_out,
    input wire         sdio_oe,
    input wire         serial_data_out,
    input wire         serial_data_out_oe,
    input wire [255:0] config_regs
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // =================================================================
    // pin enables against chip select and the data-pin mode
    property p_idle_z;
        chip_select_n [*3] |-> !sdio_oe && !serial_data_out_oe;
    endproperty
    a_idle_z: assert property (p_idle_z)
        else $error("data pin driven while deselected");
    property p_one_pin;
        !(sdio_oe && serial_data_out_oe);
    endproperty
    a_one_pin: assert property (p_one_pin)
        else $error("both data pins driven");
    property p_sdo_mode;
        serial_data_out_oe |-> !config_regs[7];
    endproperty
    a_sdo_mode: assert property (p_sdo_mode)
        else $error("separate output driven in shared-pin mode");
    property p_bidir_mode;
        sdio_oe |-> config_regs[7];
    endproperty
    a_bidir_mode: assert property (p_bidir_mode)
        else $error("shared pin driven in two-pin mode");
    // =================================================================
    // register file and output bit timing
    property p_rev_slot;
        config_regs[255:248] == 8'h00;
    endproperty
    a_rev_slot: assert property (p_rev_slot)
        else $error("revision slot holds storage");
    property p_cfg_on_rise;
        $changed(config_regs) |-> sclk;
    endproperty
    a_cfg_on_rise: assert property (p_cfg_on_rise)
        else $error("register changed while serial clock low");
    property p_no_idle_write;
        chip_select_n [*4] |-> $stable(config_regs);
    endproperty
    a_no_idle_write: assert property (p_no_idle_write)
        else $error("register changed while deselected");
    property p_drive_on_fall;
        $changed(serial_data_out) && (serial_data_out_oe || sdio_oe) |-> !sclk;
    endproperty
    a_drive_on_fall: assert property (p_drive_on_fall)
        else $error("output bit changed while serial clock high");
    c_cfg_write: cover property ($changed(config_regs[7:0]));
    c_bidir_read: cover property ($rose(sdio_oe));
    c_sdo_on: cover property ($rose(serial_data_out_oe));
endmodule // twcp_checker
bind twcp_port twcp_checker u_twcp_checker (.clk_sys(clk_sys),
    .reset_n(reset_n), .sclk(sclk), .chip_select_n(chip_select_n),
    .sdio_out(sdio_out), .sdio_oe(sdio_oe),
    .serial_data_out(serial_data_out),
    .serial_data_out_oe(serial_data_out_oe), .config_regs(config_regs));

// ===== verif/twcp_host.sv
// serial master model standing in for the host controller
`timescale 1ns/1ps
module twcp_host (
    output reg  sclk,
    output reg  chip_select_n,
    output reg  mosi,
    input  wire sdio_out,
    input  wire sdio_oe,
    input  wire serial_data_out,
    input  wire serial_data_out_oe
);
    reg last;
    initial begin
        {sclk, chip_select_n, mosi, last} = 4'h4;
    end
    task frame_on;
        #62.5 chip_select_n = 1'b0;
    endtask
    // clock parks low between frames; idle gap re-arms the port
    task frame_off;
        #62.5 chip_select_n = 1'b1;
        #100;
    endtask
    // caller picks the order per byte, so a mid-frame switch is honoured
    task shift(input [7:0] b, input lsb, input integer n, output [7:0] r);
        integer i;
        reg [2:0] k;
        r = 8'h00;
        for (i = 0; i < n; i = i + 1) begin
            k = lsb ? i : 7 - i;
            mosi = b[k];
            #62.5 sclk = 1'b1;
            r[k] = serial_data_out_oe ? serial_data_out :
                   (sdio_oe ? sdio_out : ~last);
            last = r[k];
            #62.5 sclk = 1'b0;
        end
    endtask
endmodule // twcp_host

// ===== verif/three_wire_config_port_tb.sv
// self-checking bench for the configuration port
`timescale 1ns/1ps
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin \
    err_total++; $display("[ERR] %s exp %h got %h", n, e, a); end end
module three_wire_config_port_tb;
    localparam [7:0] REV = 8'h3b; // arbitrary value
    reg          clk_sys, reset_n, clk_en;
    wire         sclk, chip_select_n, mosi, sdio_out, sdio_oe;
    wire         serial_data_out, serial_data_out_oe;
    wire [255:0] config_regs;
    wire         sdio_in = sdio_oe ? sdio_out : mosi;
    integer      err_total = 0, checked = 0, i;
    reg  [7:0]   q, r;
    reg  [12:0]  rows [0:2];
    twcp_port #(.REVISION_CODE(REV)) u_twcp_port (.clk_sys(clk_sys),
        .reset_n(reset_n), .clk_en(clk_en), .sclk(sclk),
        .chip_select_n(chip_select_n), .sdio_in(sdio_in),
        .sdio_out(sdio_out), .sdio_oe(sdio_oe),
        .serial_data_out(serial_data_out),
        .serial_data_out_oe(serial_data_out_oe), .config_regs(config_regs));
    twcp_host u_twcp_host (.sclk(sclk), .chip_select_n(chip_select_n),
        .mosi(mosi), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
        .serial_data_out(serial_data_out),
        .serial_data_out_oe(serial_data_out_oe));
    task xfer(input [7:0] ins, input [7:0] d, input lsb);
        u_twcp_host.frame_on;
        u_twcp_host.shift(ins, lsb, 8, r);
        u_twcp_host.shift(d, lsb, 8, q);
        u_twcp_host.frame_off;
    endtask
    task final_report;
        if (err_total == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial begin
        #500000 err_total++;
        final_report;
    end
    initial begin
        {reset_n, clk_en} = 2'b01;
        rows[0] = {5'h05, 8'ha5};
        rows[1] = {5'h0a, 8'h3c};
        rows[2] = {5'h1e, 8'hff};
        repeat (4) @(posedge clk_sys);
        #1 reset_n = 1'b1;
        `CHK("cfg rst", 8'h00, config_regs[7:0])
        for (i = 0; i < 3; i = i + 1) begin
            xfer({3'b000, rows[i][12:8]}, rows[i][7:0], 1'b0);
            `CHK("wr", rows[i][7:0], config_regs[8*rows[i][12:8]+:8])
            xfer({3'b100, rows[i][12:8]}, 8'h00, 1'b0);
            `CHK("rd", rows[i][7:0], q)
        end
        xfer(8'h1f, 8'h00, 1'b0);
        xfer(8'h9f, 8'h00, 1'b0);
        `CHK("rev", REV, q)
        u_twcp_host.frame_on;
        u_twcp_host.shift(8'haa, 1'b0, 8, r);
        u_twcp_host.shift(8'h00, 1'b0, 8, q);
        `CHK("rd hi", 8'h3c, q)
        u_twcp_host.shift(8'h00, 1'b0, 8, q);
        `CHK("rd lo", 8'h00, q)
        u_twcp_host.frame_off;
        u_twcp_host.frame_on;
        u_twcp_host.shift(8'h05, 1'b0, 8, r);
        u_twcp_host.shift(8'h00, 1'b0, 4, r);
        u_twcp_host.frame_off;
        `CHK("abort", 8'ha5, config_regs[47:40])
        xfer(8'h05, 8'h5a, 1'b0);
        `CHK("resync", 8'h5a, config_regs[47:40])
        // a frozen port must take nothing from a whole frame
        @(posedge clk_sys);
        #1 clk_en = 1'b0;
        xfer(8'h05, 8'h77, 1'b0);
        `CHK("frozen", 8'h5a, config_regs[47:40])
        @(posedge clk_sys);
        #1 clk_en = 1'b1;
        xfer(8'h00, 8'h80, 1'b0);
        xfer(8'h85, 8'h00, 1'b0);
        `CHK("bidir rd", 8'h5a, q)
        xfer(8'h00, 8'hc0, 1'b0);
        u_twcp_host.frame_on;
        u_twcp_host.shift(8'h40, 1'b1, 8, r);
        u_twcp_host.shift(8'h40, 1'b1, 8, r);
        u_twcp_host.shift(8'h11, 1'b1, 8, r);
        u_twcp_host.shift(8'h22, 1'b1, 8, r);
        u_twcp_host.frame_off;
        `CHK("mode", 8'h40, config_regs[7:0])
        `CHK("inc", 16'h2211, config_regs[23:8])
        xfer(8'h82, 8'h00, 1'b1);
        `CHK("lsb rd", 8'h22, q)
        // order switched by the first byte; the second follows msb first
        u_twcp_host.frame_on;
        u_twcp_host.shift(8'h20, 1'b1, 8, r);
        u_twcp_host.shift(8'h00, 1'b1, 8, r);
        u_twcp_host.shift(8'h96, 1'b0, 8, r);
        u_twcp_host.frame_off;
        `CHK("switch cfg", 8'h00, config_regs[7:0])
        `CHK("switch", 8'h96, config_regs[15:8])
        // reset in mid-run, then the port must still answer
        @(posedge clk_sys);
        #1 reset_n = 1'b0;
        repeat (4) @(posedge clk_sys);
        #1 reset_n = 1'b1;
        `CHK("rst cfg", 8'h00, config_regs[7:0])
        `CHK("rst data", 8'h00, config_regs[23:16])
        xfer(8'h9f, 8'h00, 1'b0);
        `CHK("rst rev", REV, q)
        final_report;
    end
endmodule // three_wire_config_port_tb
